// [pkg/flash_protect_map.vh]
// What this block does
// - A completed latch-set instruction sets the write latch to one.
// - Latch-set acts only at the chip select rising edge after shifting.
// - A completed latch-clear instruction clears the write latch.
// - Latch-clear takes effect at the chip select rising edge.
// - A completed arm instruction arms the following status write.
// - Any other instruction after arming discards the armed state silently.
// - Status write loads only the three protect level bits and the lock.
// - Protect input low with lock set ignores every status write.
// - Protect input low lets lock go from zero to one, never back.
// - Protect input high disables locking; all four bits may change.
// - Writability uses lock and protect level before the ending edge.
// - One allowed status write may set lock and level bits together.
// - Latch-clear instruction ends an auto-increment programming sequence.
`ifndef FLASH_PROTECT_MAP_VH
`define FLASH_PROTECT_MAP_VH
`define OP_LATCH_SET    8'h01
`define OP_LATCH_CLEAR  8'h02
`define OP_STATUS_ARM   8'h03
`define OP_STATUS_WRITE 8'h04
`define OP_AUTO_INC     8'h05
`define OP_PROGRAM      8'h06
`define OP_ERASE        8'h07
`define SR_LEVEL_LSB    2
`define SR_LEVEL_MSB    4
`define SR_LOCK_BIT     7
`define PROT_RESET      3'h0
`endif

// [test/flash_write_protect_checker.sv]
module flash_write_protect_checker (
   input logic       clk_sys,         // Clock
   input logic       srst,            // Reset
   input logic       chipSelectN,     // Select
   input logic       writeProtectN,   // Protect pin
   input logic       writeLatch,      // Latch
   input logic [2:0] protectLevel,    // Level bits
   input logic       protectLock,     // Lock bit
   input logic       statusArmed,     // Armed
   input logic       autoIncActive,   // Auto-inc
   input logic       writeStart,      // Start pulse
   input logic       statusWriteDone  // Done pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Pin low long enough to pass the synchroniser while locked
   sequence s_locked; (protectLock && !writeProtectN)[*8]; endsequence
   a_locked_holds: assert property (s_locked |=> !statusWriteDone && $stable(protectLevel))
      else $error("locked status changed");
   a_lock_stays: assert property ($fell(protectLock) |-> writeProtectN)
      else $error("lock cleared while protected");
   a_bits_need_write: assert property ($changed({protectLevel, protectLock}) |-> statusWriteDone)
      else $error("status bits changed without a write");
   a_latch_set_edge: assert property ($rose(writeLatch) |-> chipSelectN && $past(chipSelectN, 3))
      else $error("latch set inside a frame");
   a_latch_clear_edge: assert property ($fell(writeLatch) |-> chipSelectN && $past(chipSelectN, 3))
      else $error("latch cleared inside a frame");
   a_start_needs_latch: assert property (writeStart |-> $past(writeLatch))
      else $error("operation started with latch clear");
   a_done_one_pulse: assert property (statusWriteDone |-> !statusArmed ##1 !statusWriteDone)
      else $error("done pulse or arm wrong");
   a_auto_exit: assert property ($fell(autoIncActive) |-> !writeLatch)
      else $error("auto-increment left without clear");
endmodule
bind flash_write_protect flash_write_protect_checker i_chk (.clk_sys, .srst, .chipSelectN,
   .writeProtectN, .writeLatch, .protectLevel, .protectLock, .statusArmed, .autoIncActive,
   .writeStart, .statusWriteDone);

// [test/spi_host_model.sv]
module spi_host_model (
   input  logic clk_sys,      // Pacing clock
   output logic chipSelectN,  // Select, low active
   output logic serialClock,  // Link clock
   output logic serialIn      // Data to device
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle: deselected, link clock parked low
   initial {chipSelectN, serialClock, serialIn} = 3'h5;
   // Link clock runs only inside frames; released data shows its inverse
   task automatic frame(input logic [15:0] w, input int n);
      @(negedge clk_sys) chipSelectN = 0;
      for (int i = 0; i < n; i++) begin
         serialIn = w[15-i];
         repeat (8) @(negedge clk_sys);
         serialClock = 1;
         repeat (8) @(negedge clk_sys);
         serialClock = 0;
      end
      repeat (8) @(negedge clk_sys);
      chipSelectN = 1;
      serialIn = ~serialIn;
   endtask
endmodule

// [test/test_flash_write_protect.sv]
module test_flash_write_protect;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 0, srst = 1, writeProtectN = 1;
   logic        chipSelectN, serialClock, serialIn, writeLatch, protectLock;
   logic        statusArmed, autoIncActive, writeStart, statusWriteDone;
   logic [2:0]  protectLevel;
   int          n_fail = 0, num_checks = 0, cycles = 0, nStarts = 0, nDone = 0;
   // Op, data, bits, {mask, pin}, expected {latch, armed, auto-inc, level, lock}
   logic [39:0] rows [19] = '{40'h0100080140, 40'h0200080100, 40'h0100070100, 40'h0300080120,
      40'h0100080140, 40'h0300080160, 40'h0488100105, 40'h0300080025, 40'h0404100205,
      40'h0300080305, 40'h0400100100, 40'h0100080040, 40'h0480100001, 40'h0100080141,
      40'h0600080101, 40'h0700080101, 40'h0100080141, 40'h0500080151, 40'h0200080101};
   always #5 clk_sys = ~clk_sys;
   flash_write_protect i_dut (.clk_sys, .srst, .chipSelectN, .serialClock, .serialIn,
      .writeProtectN, .writeLatch, .protectLevel, .protectLock, .statusArmed,
      .autoIncActive, .writeStart, .statusWriteDone);
   spi_host_model i_host (.clk_sys, .chipSelectN, .serialClock, .serialIn);
   // Mask hides latch and arm on the refused write row and on the arm row after it
   task automatic check(input logic [6:0] e, input logic m);
      logic [6:0] got;
      got = {writeLatch, statusArmed, autoIncActive, protectLevel, protectLock};
      if (m) got[6:5] = e[6:5];
      num_checks++;
      if (got !== e) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, e);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Run needs about 3350 cycles; stop a hang well beyond that
   always @(posedge clk_sys) begin
      cycles++;
      if (writeStart) nStarts++;
      if (statusWriteDone) nDone++;
      if (cycles == 20000) begin
         n_fail++;
         conclude;
      end
   end
   // Table rows, then a reset in mid-run with the lock set
   initial begin
      repeat (8) @(negedge clk_sys);
      srst = 0;
      check(7'h00, 0);
      repeat (3) @(negedge clk_sys);
      foreach (rows[k]) begin
         writeProtectN = rows[k][8];
         i_host.frame(rows[k][39:24], rows[k][23:16]);
         repeat (12) @(negedge clk_sys);
         check(rows[k][6:0], rows[k][9]);
      end
      srst = 1;
      repeat (8) @(negedge clk_sys);
      srst = 0;
      check(7'h00, 0);
      num_checks += 2;
      if (nStarts != 2) begin
         n_fail++;
         $display("BAD %0t start pulses %0d want 2", $time, nStarts);
      end
      if (nDone != 3) begin
         n_fail++;
         $display("BAD %0t done pulses %0d want 3", $time, nDone);
      end
      conclude;
   end
endmodule

// [verilog/flash_write_protect.v]
`include "flash_protect_map.vh"
module flash_write_protect #(
   parameter [7:0] OP_LATCH_SET    = `OP_LATCH_SET,
   parameter [7:0] OP_LATCH_CLEAR  = `OP_LATCH_CLEAR,
   parameter [7:0] OP_STATUS_ARM   = `OP_STATUS_ARM,
   parameter [7:0] OP_STATUS_WRITE = `OP_STATUS_WRITE,
   parameter [7:0] OP_AUTO_INC     = `OP_AUTO_INC,
   parameter [7:0] OP_PROGRAM      = `OP_PROGRAM,
   parameter [7:0] OP_ERASE        = `OP_ERASE
) (
   input  wire       clk_sys,          // System clock, 100 MHz
   input  wire       srst,             // Synchronous reset, high
   input  wire       chipSelectN,      // Chip select pin, low active
   input  wire       serialClock,      // Serial clock pin
   input  wire       serialIn,         // Serial data pin
   input  wire       writeProtectN,    // Write-protect pin, low protects
   output reg        writeLatch,       // Write latch state
   output reg  [2:0] protectLevel,     // Protect level bits 2..0
   output reg        protectLock,      // Protect lock bit
   output reg        statusArmed,      // Status write armed
   output reg        autoIncActive,    // Auto-increment sequence active
   output reg        writeStart,       // Pulse: program/erase/auto-inc accepted
   output reg        statusWriteDone   // Pulse: status bits were written
);
   wire [3:0] pinSync;
   wire       csN  = pinSync[0];
   wire       sck  = pinSync[1];
   wire       sdi  = pinSync[2];
   wire       wpN  = pinSync[3];

   reg        csPrev;
   reg        sckPrev;
   reg        wpAtEdge;
   reg [7:0]  opcode;
   reg [7:0]  dataByte;
   reg [4:0]  bitCount;

   wire       csRise   = csN & ~csPrev;
   wire       sckRise  = sck & ~sckPrev & ~csN;
   wire       opDone   = (bitCount >= 5'd8);
   wire       dataDone = (bitCount >= 5'd16);

   // Protect rules: true when a status write may land
   function statusWritable;
      input lockBit;
      input wpLevel;
      begin
         statusWritable = ~lockBit | wpLevel;
      end
   endfunction

   // All pins come from the host's domain
   // Idle levels: chip select and write-protect high, clock and data low
   sync2 #(
      .WIDTH (4),
      .IDLE  (4'h9)
   ) u_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .async   ({writeProtectN, serialIn, serialClock, chipSelectN}),
      .synced  (pinSync)
   );

   // Edge history of synchronised pins
   always @(posedge clk_sys) begin
      if (srst) begin
         csPrev  <= 1'b1;
         sckPrev <= 1'b0;
      end else begin
         csPrev  <= csN;
         sckPrev <= sck;
      end
   end

   // Shift first eight bits as opcode, next eight as data, MSB first
   always @(posedge clk_sys) begin
      if (srst) begin
         opcode   <= 8'h00;
         dataByte <= 8'h00;
         bitCount <= 5'd0;
      end else if (csN) begin
         bitCount <= 5'd0;
      end else if (sckRise) begin
         if (!opDone)
            opcode <= {opcode[6:0], sdi};
         else if (!dataDone)
            dataByte <= {dataByte[6:0], sdi};
         if (!dataDone)
            bitCount <= bitCount + 5'd1;
      end
   end

   // Protect level seen just before the ending edge, resampled on every clock
   always @(posedge clk_sys) begin
      if (srst)
         wpAtEdge <= 1'b1;
      else
         wpAtEdge <= wpN;
   end

   // A frame counts only once its opcode is complete; short frames are
   // dropped whole, so a glitch on chip select cannot disarm a status write
   wire       frameEnd  = csRise & opDone;

   // Instruction classes of the frame that just closed
   wire       isSet     = (opcode == OP_LATCH_SET);
   wire       isClear   = (opcode == OP_LATCH_CLEAR);
   wire       isArm     = (opcode == OP_STATUS_ARM);
   wire       isStatus  = (opcode == OP_STATUS_WRITE);
   wire       isAutoInc = (opcode == OP_AUTO_INC);
   wire       isProgram = (opcode == OP_PROGRAM);
   wire       isErase   = (opcode == OP_ERASE);
   wire       isWriteOp = isProgram | isErase | isAutoInc;

   // A status write needs a whole data byte and either arm or latch;
   // bits past the sixteenth are ignored, so longer frames still work
   wire       statusOpen  = (statusArmed | writeLatch) & dataDone;

   // Lock and pin as they stood before the ending edge decide writability
   wire       statusAllow = statusOpen &
                            statusWritable(protectLock, wpAtEdge);

   // New status fields taken from the data byte
   wire [2:0] newLevel    = dataByte[`SR_LEVEL_MSB:`SR_LEVEL_LSB];
   wire       newLock     = dataByte[`SR_LOCK_BIT];

   reg        next_writeLatch;
   reg  [2:0] next_protectLevel;
   reg        next_protectLock;
   reg        next_statusArmed;
   reg        next_autoIncActive;
   reg        next_writeStart;
   reg        next_statusWriteDone;

   // Next state; everything holds unless a complete frame just ended.
   // Pulses default low so they last exactly one clock.
   always @* begin
      next_writeLatch      = writeLatch;
      next_protectLevel    = protectLevel;
      next_protectLock     = protectLock;
      next_statusArmed     = statusArmed;
      next_autoIncActive   = autoIncActive;
      next_writeStart      = 1'b0;
      next_statusWriteDone = 1'b0;
      if (frameEnd) begin
         // Arm lives for exactly one following instruction
         next_statusArmed = 1'b0;
         if (isSet) begin
            next_writeLatch = 1'b1;
         end else if (isClear) begin
            next_writeLatch    = 1'b0;
            next_autoIncActive = 1'b0;
         end else if (isArm) begin
            next_statusArmed = 1'b1;
         end else if (isStatus) begin
            // Only the level bits and the lock are ever loaded
            if (statusAllow) begin
               next_protectLevel    = newLevel;
               next_protectLock     = newLock;
               next_statusWriteDone = 1'b1;
            end
            // The latch is spent even by a refused status write
            next_writeLatch = 1'b0;
         end else if (isWriteOp) begin
            // No latch, no operation
            if (writeLatch) begin
               next_writeStart = 1'b1;
               if (isAutoInc) begin
                  // Auto-inc keeps the latch; a later latch-clear, status write, program or erase clears it
                  next_autoIncActive = 1'b1;
               end else begin
                  next_writeLatch = 1'b0;
               end
            end
         end
      end
   end

   // Register stage: every output leaves straight from a flop
   always @(posedge clk_sys) begin
      if (srst) begin
         writeLatch      <= 1'b0;
         protectLevel    <= `PROT_RESET;
         protectLock     <= 1'b0;
         statusArmed     <= 1'b0;
         autoIncActive   <= 1'b0;
         writeStart      <= 1'b0;
         statusWriteDone <= 1'b0;
      end else begin
         writeLatch      <= next_writeLatch;
         protectLevel    <= next_protectLevel;
         protectLock     <= next_protectLock;
         statusArmed     <= next_statusArmed;
         autoIncActive   <= next_autoIncActive;
         writeStart      <= next_writeStart;
         statusWriteDone <= next_statusWriteDone;
      end
   end
endmodule

// [verilog/sync2.v]
module sync2 #(
   parameter WIDTH = 4,
   parameter IDLE  = 4'h0
) (
   input  wire             clk_sys,  // System clock
   input  wire             srst,     // Synchronous reset
   input  wire [WIDTH-1:0] async,    // Asynchronous levels
   output reg  [WIDTH-1:0] synced    // Synchronised levels
);
   reg [WIDTH-1:0] stage1;

   // Two flops; stage1 feeds nothing but stage two
   // Reset to the pins' idle levels so no false edge follows reset
   always @(posedge clk_sys) begin
      if (srst) begin
         stage1 <= IDLE[WIDTH-1:0];
         synced <= IDLE[WIDTH-1:0];
      end else begin
         stage1 <= async;
         synced <= stage1;
      end
   end
endmodule
